// file: hdl/framer_cfg.svh
// Constants for the image readout framer
`ifndef FRAMER_CFG_SVH
`define FRAMER_CFG_SVH
`define CMD_RESET 6'h01
`define CMD_READ 6'h02
`define ARG_ENDLESS 8'h80
`define IDLE_WORD 16'h55aa
`define SYNC_DEFAULT 32'h1acf_fc1d
`define END_DEFAULT 32'he0f0_c3a5
`define FRAME_WORDS 18'h25805
`define HDR_WORDS 18'h00003
`define W_SYNC_HI 18'h00000
`define W_SYNC_LO 18'h00001
`define W_ID 18'h00002
`define CLK_HZ 50000000
`define WAKE_S 3
`define STARTUP_S 147
`define ACQ_BASE_MS 400
`define SETTLE_MS 2
`define REFRESH_S 1
`define MS_PER_S 1000
`define FIFO_DEPTH 8
`endif

// file: hdl/framer_pkg.sv
// Types shared by the image readout framer
package framer_pkg;
  typedef enum logic [1:0] {
    ST_WAKE = 2'b00,
    ST_ACQ = 2'b01,
    ST_READY = 2'b10
  } state_e;
  typedef enum logic [1:0] {
    FP_ADDR_HI = 2'b00,
    FP_ADDR_LO = 2'b01,
    FP_CAP_HI = 2'b10,
    FP_PUSH = 2'b11
  } fetch_e;
  typedef logic [15:0] word_t;
endpackage

// file: hdl/image_acquire_readout_framer.sv
// Image acquisition control, word FIFO and framed readout to the poller
//
// Function
// - Acquire command code 000010 with argument N in 0..127 takes N+1 images.
// - Argument 128 acquires and outputs frames endlessly until new command or reset.
// - Below 128 frames run back to back; last frame stays readable again.
// - Endless with serial output: refresh image if unpolled one second after acquisition.
// - New acquire command cancels old one after the current frame is fully output.
// - Acquire plus download is atomic; every frame read once before new command.
// - Frame opens with 32-bit sync, 8-bit identifier, then status octet.
// - Identifier steps once per acquired image; rereads repeat the same value.
// - Status octet carries the sensor latch-up alarm.
// - Pixels go top-left to bottom-right, one value per pixel.
// - Each word packs two pixels, earlier pixel in upper byte.
// - A 32-bit end marker closes every frame after the last pixel word.
// - Polls with no image available return alternating 0x55 and 0xAA bytes.
// - Paused polling keeps position; download resumes at the next word.
// - After power-on wait 3 s wake-up plus 147 s before first acquisition.
// - Picture is ready 400 ms plus exposure time after acquisition starts.
// - A full download is exactly 153605 sixteen-bit reads.
// - After full download the device settles 2 ms before next command.
// - Reset command code 000001 acts at once like power-on reset.
// - Commands with parity error or unknown code are dropped without effect.
`timescale 1ns/1ps
`include "framer_cfg.svh"

module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= bump(wr_q);
      if (pop) rd_q <= bump(rd_q);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // word_fifo

module image_acquire_readout_framer
  import framer_pkg::*;
#(
  parameter logic [31:0] SYNC_PAT = `SYNC_DEFAULT,
  parameter logic [31:0] END_PAT = `END_DEFAULT,
  parameter logic [17:0] FRAME_WORDS = `FRAME_WORDS,
  parameter logic [39:0] STARTUP_CYC =
    40'(64'(`WAKE_S + `STARTUP_S) * 64'(`CLK_HZ)),
  parameter logic [31:0] ACQ_BASE_CYC =
    32'(`ACQ_BASE_MS * (`CLK_HZ / `MS_PER_S)),
  parameter logic [31:0] SETTLE_CYC =
    32'(`SETTLE_MS * (`CLK_HZ / `MS_PER_S)),
  parameter logic [31:0] REFRESH_CYC = 32'(`REFRESH_S * `CLK_HZ)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [5:0] cmd_code,
  input wire logic [7:0] cmd_arg,
  input wire logic cmd_parity_ok,
  input wire logic [31:0] exposure_cycles,
  input wire logic latchup_alarm,
  input wire logic serial_out_sel,
  input wire logic poll_req,
  input wire logic [7:0] buf_data,
  output logic resp_valid,
  output word_t resp_data,
  output logic [18:0] buf_addr,
  output logic acq_active
);
  localparam logic [17:0] LAST_WORD = FRAME_WORDS - 18'h1;
  localparam logic [17:0] END_HI = FRAME_WORDS - 18'h2;

  state_e state_q;
  fetch_e f_ph_q;
  logic [39:0] wake_cnt_q;
  logic [31:0] acq_cnt_q;
  logic [31:0] settle_q;
  logic [31:0] refresh_q;
  logic pend_q;
  logic [7:0] pend_arg_q;
  logic [7:0] left_q;
  logic endless_q;
  logic [7:0] id_q;
  logic [7:0] status_q;
  logic read_once_q;
  logic [17:0] dl_idx_q;
  logic [17:0] f_idx_q;
  logic [7:0] hi_q;
  logic [18:0] buf_addr_q;
  logic resp_valid_q;
  word_t resp_data_q;
  logic acq_active_q;
  word_t f_out;
  logic f_out_valid;
  logic f_in_ready;

  // Command decode; bad parity or unknown code leaves state alone
  wire soft_rst = cmd_valid && cmd_parity_ok && cmd_code == `CMD_RESET;
  wire rst_all = !rst_n || soft_rst;
  wire read_cmd = cmd_valid && cmd_parity_ok && cmd_code == `CMD_READ
    && cmd_arg <= `ARG_ENDLESS;

  wire ready_st = state_q == ST_READY;
  wire more = endless_q || left_q != 8'h00;
  wire refresh_fire = endless_q && serial_out_sel
    && refresh_q == 32'h0;
  // Next acquisition only between downloads, never mid frame
  wire start_acq = (state_q == ST_WAKE && wake_cnt_q == 40'h0)
    || (ready_st && dl_idx_q == 18'h0 && settle_q == 32'h0
    && ((read_once_q && (pend_q || more)) || refresh_fire));
  wire acq_done = state_q == ST_ACQ && acq_cnt_q == 32'h0;

  wire pop = poll_req && ready_st && f_out_valid;
  wire last_pop = pop && dl_idx_q == LAST_WORD;
  wire fetching = ready_st && f_idx_q != FRAME_WORDS;
  wire is_pix = f_idx_q >= `HDR_WORDS && f_idx_q < END_HI;
  wire [17:0] pix_word = f_idx_q - `HDR_WORDS;
  wire [18:0] pix_addr = {pix_word, 1'b0};
  wire push = fetching && (!is_pix || f_ph_q == FP_PUSH);
  wire advance = push && f_in_ready;

  // Word selection by position within the frame
  wire word_t sync_word = (f_idx_q == `W_SYNC_HI) ? SYNC_PAT[31:16]
    : SYNC_PAT[15:0];
  wire word_t end_word = (f_idx_q == END_HI) ? END_PAT[31:16]
    : END_PAT[15:0];
  wire word_t f_word = (f_idx_q < `W_ID) ? sync_word
    : (f_idx_q == `W_ID) ? {id_q, status_q}
    : is_pix ? {hi_q, buf_data}
    : end_word;

  word_fifo #(
    .WIDTH(16),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .flush(rst_all || start_acq),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data(f_word),
    .out_valid(f_out_valid),
    .out_ready(pop),
    .out_data(f_out)
  );

  always_ff @(posedge clk) begin
    if (rst_all) begin
      state_q <= ST_WAKE;
    end else if (start_acq) begin
      state_q <= ST_ACQ;
    end else if (acq_done) begin
      state_q <= ST_READY;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      wake_cnt_q <= STARTUP_CYC;
    end else if (wake_cnt_q != 40'h0) begin
      wake_cnt_q <= wake_cnt_q - 40'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (start_acq) begin
      acq_cnt_q <= ACQ_BASE_CYC + exposure_cycles;
    end else if (state_q == ST_ACQ && acq_cnt_q != 32'h0) begin
      acq_cnt_q <= acq_cnt_q - 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      settle_q <= 32'h0;
    end else if (last_pop) begin
      settle_q <= SETTLE_CYC;
    end else if (settle_q != 32'h0) begin
      settle_q <= settle_q - 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all || acq_done) begin
      refresh_q <= REFRESH_CYC;
    end else if (refresh_q != 32'h0) begin
      refresh_q <= refresh_q - 32'h1;
    end
  end

  // A command landing as the old one is taken stays pending
  always_ff @(posedge clk) begin
    if (rst_all) begin
      pend_q <= 1'b0;
      pend_arg_q <= 8'h00;
    end else if (read_cmd) begin
      pend_q <= 1'b1;
      pend_arg_q <= cmd_arg;
    end else if (start_acq) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      left_q <= 8'h00;
      endless_q <= 1'b0;
    end else if (start_acq && pend_q) begin
      left_q <= pend_arg_q;
      endless_q <= pend_arg_q == `ARG_ENDLESS;
    end else if (start_acq && left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      id_q <= 8'h00;
      status_q <= 8'h00;
    end else if (acq_done) begin
      id_q <= id_q + 8'h01;
      status_q <= {7'h00, latchup_alarm};
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all || start_acq || last_pop) begin
      dl_idx_q <= 18'h0;
    end else if (pop) begin
      dl_idx_q <= dl_idx_q + 18'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all || start_acq) begin
      read_once_q <= 1'b0;
    end else if (last_pop) begin
      read_once_q <= 1'b1;
    end
  end

  // Fetch restarts after each full download so the frame can be reread
  always_ff @(posedge clk) begin
    if (rst_all || start_acq || last_pop) begin
      f_idx_q <= 18'h0;
    end else if (advance) begin
      f_idx_q <= f_idx_q + 18'h1;
    end
  end

  // Two byte reads per pixel word; buffer answers one cycle after address
  always_ff @(posedge clk) begin
    if (rst_all || start_acq || last_pop || !fetching || !is_pix) begin
      f_ph_q <= FP_ADDR_HI;
    end else begin
      unique case (f_ph_q)
        FP_ADDR_HI: f_ph_q <= FP_ADDR_LO;
        FP_ADDR_LO: f_ph_q <= FP_CAP_HI;
        FP_CAP_HI: f_ph_q <= FP_PUSH;
        FP_PUSH: f_ph_q <= f_in_ready ? FP_ADDR_HI : FP_PUSH;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      buf_addr_q <= 19'h0;
    end else if (fetching && is_pix && f_ph_q == FP_ADDR_HI) begin
      buf_addr_q <= pix_addr;
    end else if (fetching && is_pix && f_ph_q == FP_ADDR_LO) begin
      buf_addr_q <= pix_addr | 19'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (f_ph_q == FP_CAP_HI) begin
      hi_q <= buf_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      resp_valid_q <= 1'b0;
      resp_data_q <= `IDLE_WORD;
      acq_active_q <= 1'b0;
    end else begin
      resp_valid_q <= poll_req;
      resp_data_q <= pop ? f_out : `IDLE_WORD;
      acq_active_q <= start_acq || (state_q == ST_ACQ && !acq_done);
    end
  end

  assign resp_valid = resp_valid_q;
  assign resp_data = resp_data_q;
  assign buf_addr = buf_addr_q;
  assign acq_active = acq_active_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  reset_cmd_a: assert property (
    soft_rst |=> state_q == ST_WAKE && id_q == 8'h00 && !pend_q)
    else $error("reset command did not restart the device");
  bad_cmd_a: assert property (
    cmd_valid && !cmd_parity_ok && !start_acq
    |=> $stable(pend_q) && $stable(pend_arg_q))
    else $error("faulty command changed pending state");
  idle_pat_a: assert property (
    poll_req && !ready_st && !soft_rst
    |=> resp_valid_q && resp_data_q == `IDLE_WORD)
    else $error("idle pattern missing while no image");
  sync_first_a: assert property (
    pop && dl_idx_q == 18'h0 && !soft_rst
    |=> resp_data_q == SYNC_PAT[31:16])
    else $error("frame did not open with sync pattern");
  id_step_a: assert property (
    acq_done && !soft_rst |=> id_q == $past(id_q) + 8'h01)
    else $error("identifier did not step on acquisition");
  end_word_a: assert property (
    last_pop && !soft_rst
    |=> resp_data_q == END_PAT[15:0] && dl_idx_q == 18'h0)
    else $error("frame did not close with end marker");
  stall_keep_a: assert property (
    ready_st && !poll_req && !start_acq && !soft_rst
    |=> $stable(dl_idx_q))
    else $error("download position moved without a poll");
  acq_hold_a: assert property (
    state_q == ST_ACQ && acq_cnt_q != 32'h0 && !soft_rst
    |=> state_q == ST_ACQ)
    else $error("image ready before acquisition time");
endmodule // image_acquire_readout_framer

// file: tb/pixel_buffer_model.sv
// Image buffer model: synchronous RAM seen from the framer's buffer port
`timescale 1ns/1ps
module pixel_buffer_model (
  input wire logic clk,
  input wire logic [18:0] buf_addr,
  output logic [7:0] buf_data
);
  // Content is a function of the address so the bench can predict each byte
  always_ff @(posedge clk) begin
    buf_data <= buf_addr[7:0] ^ 8'h5c;
  end
endmodule // pixel_buffer_model

// file: tb/tb.sv
// Self-checking bench for the image readout framer
`timescale 1ns/1ps
`include "framer_cfg.svh"
module tb;
  import framer_pkg::*;
  localparam logic [17:0] FW = 18'h00009;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [5:0] cmd_code = 6'h00;
  logic [7:0] cmd_arg = 8'h00;
  logic cmd_parity_ok = 1'b1;
  logic [31:0] exposure_cycles = 32'h00000005;
  logic latchup_alarm = 1'b1;
  logic serial_out_sel = 1'b0;
  logic poll_req = 1'b0;
  logic [7:0] buf_data;
  logic resp_valid;
  word_t resp_data;
  logic [18:0] buf_addr;
  logic acq_active;
  logic acq_prev = 1'b0;
  int failures = 0;
  int check_count = 0;
  int acq_starts = 0;
  int cyc = 0;

  image_acquire_readout_framer #(
    .FRAME_WORDS(FW),
    .STARTUP_CYC(40'h00000000c8),
    .ACQ_BASE_CYC(32'h00000032),
    .SETTLE_CYC(32'h0000000a),
    .REFRESH_CYC(32'h0000012c)
  ) uut (
    .clk(clk),
    .rst_n(rst_n),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .cmd_arg(cmd_arg),
    .cmd_parity_ok(cmd_parity_ok),
    .exposure_cycles(exposure_cycles),
    .latchup_alarm(latchup_alarm),
    .serial_out_sel(serial_out_sel),
    .poll_req(poll_req),
    .buf_data(buf_data),
    .resp_valid(resp_valid),
    .resp_data(resp_data),
    .buf_addr(buf_addr),
    .acq_active(acq_active)
  );

  pixel_buffer_model buf_model (
    .clk(clk),
    .buf_addr(buf_addr),
    .buf_data(buf_data)
  );

  always #10 clk = ~clk;

  // Counts acquisition starts and cuts a hang short
  always @(posedge clk) begin
    if (acq_active === 1'b1 && acq_prev !== 1'b1)
      acq_starts++;
    acq_prev = acq_active;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic send_cmd(input logic [5:0] c, input logic [7:0] a,
                          input logic par);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_arg <= a;
    cmd_parity_ok <= par;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_parity_ok <= 1'b1;
  endtask

  task automatic poll(output word_t w);
    @(posedge clk);
    poll_req <= 1'b1;
    @(posedge clk);
    poll_req <= 1'b0;
    @(negedge clk);
    chk(resp_valid, 1'b1);
    w = resp_data;
    repeat (3) @(posedge clk);
  endtask

  // Waits for one acquisition to run through, with a bound
  task automatic wait_image();
    int n = 0;
    int h = 0;
    bit rise = (acq_active !== 1'b1);
    while (acq_active !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    while (acq_active !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
      h++;
    end
    chk(n < 2000, 1'b1);
    // Whole busy time seen only when the start was caught: base plus exposure plus one cycle
    if (rise)
      chk(h, 32'h00000038);
    repeat (2) @(posedge clk);
  endtask

  function automatic word_t exp_word(int i, logic [7:0] id, logic st);
    logic [7:0] b;
    b = 8'(2 * (i - 3)) ^ 8'h5c;
    if (i == 0)
      return 16'(`SYNC_DEFAULT >> 16);
    if (i == 1)
      return 16'(`SYNC_DEFAULT);
    if (i == 2)
      return {id, 7'h00, st};
    if (i == FW - 2)
      return 16'(`END_DEFAULT >> 16);
    if (i == FW - 1)
      return 16'(`END_DEFAULT);
    return {b, b ^ 8'h01};
  endfunction

  // Reads words first..last of a frame; a long stall after word 4 if asked
  task automatic read_words(int first, int last, logic [7:0] id, logic st,
                            logic pause);
    word_t w;
    for (int i = first; i <= last; i++) begin
      poll(w);
      chk(w, exp_word(i, id, st));
      if (pause && i == 4)
        repeat (40) @(posedge clk);
    end
  endtask

  task automatic t_startup();
    word_t w;
    int n = 0;
    poll(w);
    chk(w, `IDLE_WORD);
    while (acq_active !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(n >= 190 && n <= 205, 1'b1);
    poll(w);
    chk(w, `IDLE_WORD);
    wait_image();
  endtask

  task automatic t_first();
    read_words(0, FW - 1, 8'h01, 1'b1, 1'b1);
    read_words(0, FW - 1, 8'h01, 1'b1, 1'b0);
    latchup_alarm <= 1'b0;
  endtask

  task automatic t_refused();
    int s = acq_starts;
    send_cmd(`CMD_READ, 8'h00, 1'b0);
    send_cmd(6'h05, 8'h00, 1'b1);
    send_cmd(`CMD_READ, 8'h81, 1'b1);
    send_cmd(`CMD_RESET, 8'h01, 1'b0);
    repeat (150) @(posedge clk);
    chk(acq_starts, s);
    // A dropped reset leaves the buffered frame readable as before
    read_words(0, FW - 1, 8'h01, 1'b1, 1'b0);
  endtask

  task automatic t_multi();
    word_t w;
    int s;
    send_cmd(`CMD_READ, 8'h01, 1'b1);
    wait_image();
    read_words(0, FW - 1, 8'h02, 1'b0, 1'b0);
    while (acq_active !== 1'b1 && s < 300) begin
      @(posedge clk);
      s++;
    end
    chk(s, 9);
    poll(w);
    chk(w, `IDLE_WORD);
    wait_image();
    read_words(0, FW - 1, 8'h03, 1'b0, 1'b0);
    s = acq_starts;
    repeat (200) @(posedge clk);
    chk(acq_starts, s);
    read_words(0, FW - 1, 8'h03, 1'b0, 1'b0);
  endtask

  task automatic t_cancel();
    int s;
    send_cmd(`CMD_READ, `ARG_ENDLESS, 1'b1);
    wait_image();
    read_words(0, 2, 8'h04, 1'b0, 1'b0);
    send_cmd(`CMD_READ, 8'h00, 1'b1);
    s = acq_starts;
    read_words(3, FW - 1, 8'h04, 1'b0, 1'b0);
    chk(acq_starts, s);
    wait_image();
    read_words(0, FW - 1, 8'h05, 1'b0, 1'b0);
    s = acq_starts;
    repeat (400) @(posedge clk);
    chk(acq_starts, s);
  endtask

  task automatic t_refresh_reset();
    word_t w;
    serial_out_sel <= 1'b1;
    send_cmd(`CMD_READ, `ARG_ENDLESS, 1'b1);
    wait_image();
    wait_image();
    read_words(0, 3, 8'h07, 1'b0, 1'b0);
    send_cmd(`CMD_RESET, 8'h01, 1'b1);
    serial_out_sel <= 1'b0;
    poll(w);
    chk(w, `IDLE_WORD);
    chk(acq_active, 1'b0);
    wait_image();
    read_words(0, FW - 1, 8'h01, 1'b0, 1'b0);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_startup();
    t_first();
    t_refused();
    t_multi();
    t_cancel();
    t_refresh_reset();
    finish_test();
  end
endmodule // tb
